// ### rtl/bexec_pkg.sv
// Purpose: Shared constants for the branch and bit-set execution block.
// Assumes: 16-bit instruction words, 21-bit byte program counter.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
//
// Behaviour
// RULE1: Opcode high byte E3 branches when the carry flag is clear.
// RULE2: Opcode high byte E7 branches when the negative flag is clear.
// RULE3: Opcode high byte E5 branches when the overflow flag is clear.
// RULE4: Opcode high byte E1 branches when the zero flag is clear.
// RULE5: A conditional branch carries a signed 8-bit offset, -128 to 127.
// RULE6: A taken branch loads the incremented counter plus twice the offset.
// RULE7: A conditional branch takes one cycle, or two when taken.
// RULE8: Top bits 11010 form a relative jump with an 11-bit signed offset.
// RULE9: The relative jump always takes two cycles, the second idle.
// RULE10: Top nibble 1000 sets bit bbb of the addressed file register.
// RULE11: With the bank bit clear the access bank is addressed.
// RULE12: With the bank bit set the bank select register picks the bank.
// RULE13: Bank bit clear, extended set on, address up to 95 is indexed.
// RULE14: None of these instructions changes any status flag.
// RULE15: The idle cycle of a taken branch flushes the prefetched word.
// RULE16: High bytes E2 and E6 branch on carry set and negative set.
package bexec_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BANK = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0C;
  localparam logic [7:0] REG_INSTR = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;
  localparam logic [7:0] REG_IDX_BASE = 8'h18;

  localparam int CTRL_EXT_BIT = 0;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_OV = 2;
  localparam int FLAG_N = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [7:0] OP_BR_ZERO_SET = 8'hE0;
  localparam logic [7:0] OP_BR_ZERO_CLR = 8'hE1;
  localparam logic [7:0] OP_BR_CARRY_SET = 8'hE2;
  localparam logic [7:0] OP_BR_CARRY_CLR = 8'hE3;
  localparam logic [7:0] OP_BR_OVF_SET = 8'hE4;
  localparam logic [7:0] OP_BR_OVF_CLR = 8'hE5;
  localparam logic [7:0] OP_BR_NEG_SET = 8'hE6;
  localparam logic [7:0] OP_BR_NEG_CLR = 8'hE7;
  localparam logic [4:0] OP_REL_JUMP = 5'h1A;
  localparam logic [3:0] OP_BIT_SET = 4'h8;

  // ****************************************************************
  // Addressing and timing
  // ****************************************************************
  localparam logic [7:0] IDX_MAX = 8'h5F;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} exec_state_t;

endpackage : bexec_pkg

// ### rtl/phase_gen.sv
// Purpose: Four-phase sequencer of the instruction cycle.
// Assumes: One clock; phases advance on a divided enable.
// Notes: Phase returns to decode whenever the core is idle.
`timescale 1ns/100ps
module phase_gen #(
  parameter int DIV = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  // Phase
  output logic ph_en,
  output logic [1:0] ph
);

  initial begin
    if (DIV < 1 || DIV > 255) begin
      $error("phase_gen: DIV out of range");
    end
  end

  logic [7:0] div_q;

  assign ph_en = run && (div_q == 8'(DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || ph_en) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      ph <= bexec_pkg::PH_DECODE;
    end else if (ph_en) begin
      ph <= ph + 2'h1;
    end
  end

endmodule : phase_gen

// ### rtl/bank_addr_map.sv
// Purpose: Forms the 12-bit file address of a bit-oriented instruction.
// Assumes: Sixteen banks of 256 bytes.
// Notes: Purely combinational.
`timescale 1ns/100ps
module bank_addr_map (
  // Operand fields
  input wire logic [7:0] f,
  input wire logic a_bit,
  // Banking state
  input wire logic [3:0] bank,
  input wire logic ext_en,
  input wire logic [11:0] idx_base,
  // Result
  output logic [11:0] addr
);

  always_comb begin
    // RULE12: bank register picks bank
    if (a_bit) begin
      addr = {bank, f};
    // RULE13: indexed literal offset
    end else if (ext_en && f <= bexec_pkg::IDX_MAX) begin
      addr = idx_base + {4'h0, f};
    // RULE11: access bank split
    end else if (f < bexec_pkg::ACC_SPLIT) begin
      addr = {bexec_pkg::ACC_LOW_BANK, f};
    end else begin
      addr = {bexec_pkg::ACC_HIGH_BANK, f};
    end
  end

endmodule : bank_addr_map

// ### rtl/branch_and_bit_set_exec.sv
// Purpose: Executes the conditional branches, relative jump and bit set.
// Assumes: File memory returns read data the cycle after fr_re.
// Notes: Software loads an instruction word and watches busy.
`timescale 1ns/100ps
module branch_and_bit_set_exec #(
  parameter int ADDR_W = 8,
  parameter int PHASE_DIV = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Data file port
  output logic [11:0] fr_addr,
  output logic fr_re,
  input wire logic [7:0] fr_rdata,
  output logic fr_we,
  output logic [7:0] fr_wdata,
  // Fetch side
  output logic flush,
  output logic [20:0] fetch_addr,
  output logic busy
);

  initial begin
    if (ADDR_W < 5 || ADDR_W > 8) begin
      $error("branch_and_bit_set_exec: ADDR_W out of range");
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  bexec_pkg::exec_state_t st_q;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_wr, idle;
  logic [7:0] rd_addr;

  logic ext_en_q;
  logic [3:0] flags_q, bank_q;
  logic [20:0] pc_q, off_q;
  logic [15:0] instr_q;
  logic [11:0] idx_base_q;
  logic taken_q, illegal_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  assign idle = (st_q == bexec_pkg::ST_IDLE);
  assign busy = !idle;
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;
  assign rd_addr = 8'(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= 8'(s_axi_awaddr);
    end else if (do_wr) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_wr) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= bexec_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      case (aw_addr_q)
        bexec_pkg::REG_CTRL, bexec_pkg::REG_STATUS, bexec_pkg::REG_BANK,
        bexec_pkg::REG_PC, bexec_pkg::REG_INSTR, bexec_pkg::REG_STATE,
        bexec_pkg::REG_IDX_BASE: bresp_q <= bexec_pkg::RESP_OKAY;
        default: bresp_q <= bexec_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= bexec_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= bexec_pkg::RESP_OKAY;
      case (rd_addr)
        bexec_pkg::REG_CTRL: rdata_q <= {31'h0, ext_en_q};
        bexec_pkg::REG_STATUS: rdata_q <= {28'h0, flags_q};
        bexec_pkg::REG_BANK: rdata_q <= {28'h0, bank_q};
        bexec_pkg::REG_PC: rdata_q <= {11'h0, pc_q};
        bexec_pkg::REG_INSTR: rdata_q <= {16'h0, instr_q};
        bexec_pkg::REG_STATE: rdata_q <= {29'h0, illegal_q, taken_q, busy};
        bexec_pkg::REG_IDX_BASE: rdata_q <= {20'h0, idx_base_q};
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= bexec_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [31:0] wv, idx_wv, instr_wv, pc_wv;
  logic start;

  assign wv = merge(32'h00000000, w_data_q, w_strb_q);
  assign idx_wv = merge({20'h0, idx_base_q}, w_data_q, w_strb_q);
  assign instr_wv = merge({16'h0, instr_q}, w_data_q, w_strb_q);
  assign pc_wv = merge({11'h0, pc_q}, w_data_q, w_strb_q);
  // Writes that would disturb a running instruction are dropped, except REG_CTRL writes, which update the extended bit even while busy.
  assign start = do_wr && idle && aw_addr_q == bexec_pkg::REG_INSTR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_q <= 1'b0;
      bank_q <= 4'h0;
      idx_base_q <= 12'h000;
    end else if (do_wr) begin
      if (aw_addr_q == bexec_pkg::REG_CTRL && w_strb_q[0]) begin
        ext_en_q <= wv[bexec_pkg::CTRL_EXT_BIT];
      end
      if (aw_addr_q == bexec_pkg::REG_BANK && w_strb_q[0] && idle) begin
        bank_q <= wv[3:0];
      end
      if (aw_addr_q == bexec_pkg::REG_IDX_BASE && idle) begin
        idx_base_q <= idx_wv[11:0];
      end
    end
  end

  // RULE14: flags only move by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 4'h0;
    end else if (do_wr && idle && aw_addr_q == bexec_pkg::REG_STATUS &&
                 w_strb_q[0]) begin
      flags_q <= wv[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= 16'h0000;
    end else if (start) begin
      instr_q <= instr_wv[15:0];
    end
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  logic ph_en, at_decode, at_read, at_proc, at_write, cond;
  logic [1:0] ph;
  logic [11:0] map_addr;

  phase_gen #(.DIV(PHASE_DIV)) u_phase (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(busy),
    .ph_en(ph_en),
    .ph(ph)
  );

  bank_addr_map u_map (
    .f(instr_q[7:0]),
    .a_bit(instr_q[8]),
    .bank(bank_q),
    .ext_en(ext_en_q),
    .idx_base(idx_base_q),
    .addr(map_addr)
  );

  assign at_decode = st_q == bexec_pkg::ST_EXEC && ph_en &&
                     ph == bexec_pkg::PH_DECODE;
  assign at_read = st_q == bexec_pkg::ST_EXEC && ph_en &&
                   ph == bexec_pkg::PH_READ;
  assign at_proc = st_q == bexec_pkg::ST_EXEC && ph_en &&
                   ph == bexec_pkg::PH_PROCESS;
  assign at_write = st_q == bexec_pkg::ST_EXEC && ph_en &&
                    ph == bexec_pkg::PH_WRITE;

  always_comb begin
    case (instr_q[15:8])
      // RULE4: not zero
      bexec_pkg::OP_BR_ZERO_CLR: cond = !flags_q[bexec_pkg::FLAG_Z];
      bexec_pkg::OP_BR_ZERO_SET: cond = flags_q[bexec_pkg::FLAG_Z];
      // RULE1: no carry
      bexec_pkg::OP_BR_CARRY_CLR: cond = !flags_q[bexec_pkg::FLAG_C];
      // RULE16: carry or negative set
      bexec_pkg::OP_BR_CARRY_SET: cond = flags_q[bexec_pkg::FLAG_C];
      bexec_pkg::OP_BR_NEG_SET: cond = flags_q[bexec_pkg::FLAG_N];
      // RULE3: no overflow
      bexec_pkg::OP_BR_OVF_CLR: cond = !flags_q[bexec_pkg::FLAG_OV];
      bexec_pkg::OP_BR_OVF_SET: cond = flags_q[bexec_pkg::FLAG_OV];
      // RULE2: not negative
      bexec_pkg::OP_BR_NEG_CLR: cond = !flags_q[bexec_pkg::FLAG_N];
      // RULE8: relative jump always goes
      default: cond = instr_q[15:11] == bexec_pkg::OP_REL_JUMP;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_q <= 1'b0;
      illegal_q <= 1'b0;
      off_q <= 21'h000000;
    end else if (at_decode) begin
      taken_q <= cond;
      illegal_q <= !cond && instr_q[15:11] != 5'(bexec_pkg::OP_BR_ZERO_SET
                   >> 3) && instr_q[15:12] != bexec_pkg::OP_BIT_SET;
      // RULE5: sign-extend the offset field
      if (instr_q[15:11] == bexec_pkg::OP_REL_JUMP) begin
        off_q <= {{10{instr_q[10]}}, instr_q[10:0]};
      end else begin
        off_q <= {{13{instr_q[7]}}, instr_q[7:0]};
      end
    end
  end

  // RULE7: taken branches add an idle cycle
  // RULE9: relative jump always two cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= bexec_pkg::ST_IDLE;
    end else begin
      case (st_q)
        bexec_pkg::ST_IDLE: begin
          if (start) begin
            st_q <= bexec_pkg::ST_EXEC;
          end
        end
        bexec_pkg::ST_EXEC: begin
          if (at_write) begin
            st_q <= taken_q ? bexec_pkg::ST_NOP : bexec_pkg::ST_IDLE;
          end
        end
        bexec_pkg::ST_NOP: begin
          if (ph_en && ph == bexec_pkg::PH_WRITE) begin
            st_q <= bexec_pkg::ST_IDLE;
          end
        end
        default: st_q <= bexec_pkg::ST_IDLE;
      endcase
    end
  end

  // RULE6: target is incremented count plus twice offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= 21'h000000;
    end else if (do_wr && idle && aw_addr_q == bexec_pkg::REG_PC) begin
      // Instructions sit on even addresses, so bit 0 is never stored.
      pc_q <= {pc_wv[20:1], 1'b0};
    end else if (at_decode) begin
      pc_q <= pc_q + bexec_pkg::PC_STEP;
    end else if (at_write && taken_q) begin
      pc_q <= pc_q + {off_q[19:0], 1'b0};
    end
  end

  // RULE15: drop prefetched word, refetch target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush <= 1'b0;
      fetch_addr <= 21'h000000;
    end else begin
      flush <= at_write && taken_q;
      if (at_write && taken_q) begin
        fetch_addr <= pc_q + {off_q[19:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Bit set datapath
  // ****************************************************************
  logic is_bset;
  logic [7:0] fdata_q;

  assign is_bset = instr_q[15:12] == bexec_pkg::OP_BIT_SET;

  // RULE10: read, set bit bbb, write back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fr_addr <= 12'h000;
      fr_re <= 1'b0;
      fr_we <= 1'b0;
      fr_wdata <= 8'h00;
      fdata_q <= 8'h00;
    end else begin
      // The read goes out during the read phase so the file's answer,
      // due one cycle later, stands by the end of the process phase.
      fr_re <= at_decode && is_bset;
      fr_we <= at_write && is_bset;
      if (at_decode && is_bset) begin
        fr_addr <= map_addr;
      end
      if (at_proc && is_bset) begin
        fdata_q <= fr_rdata;
      end
      if (at_write && is_bset) begin
        fr_wdata <= fdata_q | (8'h01 << instr_q[11:9]);
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  no_carry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    at_decode && instr_q[15:8] == bexec_pkg::OP_BR_CARRY_CLR |=>
    taken_q == !$past(flags_q[bexec_pkg::FLAG_C]))
    else $error("carry clear branch decision wrong"); // RULE1
  not_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    at_decode && instr_q[15:8] == bexec_pkg::OP_BR_NEG_CLR |=>
    taken_q == !$past(flags_q[bexec_pkg::FLAG_N]))
    else $error("negative clear branch decision wrong"); // RULE2
  no_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    at_decode && instr_q[15:8] == bexec_pkg::OP_BR_OVF_CLR |=>
    taken_q == !$past(flags_q[bexec_pkg::FLAG_OV]))
    else $error("overflow clear branch decision wrong"); // RULE3
  not_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    at_decode && instr_q[15:8] == bexec_pkg::OP_BR_ZERO_CLR |=>
    taken_q == !$past(flags_q[bexec_pkg::FLAG_Z]))
    else $error("zero clear branch decision wrong"); // RULE4
  off_sext_a: assert property (@(posedge aclk) disable iff (!aresetn)
    at_decode && instr_q[15:11] == 5'h1C |=>
    $signed(off_q) == $signed($past(instr_q[7:0])))
    else $error("short offset not sign extended"); // RULE5
  pc_target_a: assert property (@(posedge aclk) disable iff (!aresetn)
    at_write && taken_q |=> pc_q == $past(pc_q) + {$past(off_q[19:0]), 1'b0}
    && fetch_addr == pc_q)
    else $error("branch target wrong"); // RULE6
  cycle_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    at_write |=> (st_q == bexec_pkg::ST_NOP) == $past(taken_q))
    else $error("taken branch cycle count wrong"); // RULE7
  jump_taken_a: assert property (@(posedge aclk) disable iff (!aresetn)
    at_decode && instr_q[15:11] == bexec_pkg::OP_REL_JUMP |=> taken_q)
    else $error("relative jump not taken"); // RULE9
  bit_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fr_we |-> fr_wdata[instr_q[11:9]] && fr_re == 1'b0)
    else $error("selected bit not set"); // RULE10
  bank_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fr_we && instr_q[8] |-> fr_addr[11:8] == bank_q)
    else $error("bank register not used"); // RULE12
  flags_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    busy |=> $stable(flags_q))
    else $error("flags changed during execution"); // RULE14
  flush_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q == bexec_pkg::ST_NOP) |-> flush)
    else $error("idle cycle without flush"); // RULE15

endmodule : branch_and_bit_set_exec

// ### tb/file_mem_model.sv
// Purpose: Data file memory seen at the block's file port.
// Assumes: Read data is due the cycle after a read request.
// Notes: Each byte starts as its low address bits xor 5A.
`timescale 1ns/100ps
module file_mem_model #(
  parameter int HOLD = 1
) (
  // Clock
  input wire logic aclk,
  // File port
  input wire logic [11:0] fr_addr,
  input wire logic fr_re,
  output logic [7:0] fr_rdata,
  input wire logic fr_we,
  input wire logic [7:0] fr_wdata
);
  logic [7:0] mem [0:4095];
  int age_q;

  initial begin
    fr_rdata = 8'h00;
    age_q = 0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
  end

  // Once the hold time has run out the read bus toggles every cycle, so a
  // late sample by the block shows up as a wrong bit set result.
  always @(posedge aclk) begin
    if (fr_we) begin
      mem[fr_addr] <= fr_wdata;
    end
    if (fr_re) begin
      fr_rdata <= mem[fr_addr];
      age_q <= 0;
    end else if (age_q >= HOLD) begin
      fr_rdata <= ~fr_rdata;
    end else begin
      age_q <= age_q + 1;
    end
  end
endmodule : file_mem_model

// ### tb/tb_branch_and_bit_set_exec.sv
// Purpose: Self-checking bench for the branch and bit-set block.
// Assumes: One phase per cycle; PC starts each row at 1000h.
// Notes: Rows run the normal cases; awkward cases follow by hand.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_branch_and_bit_set_exec;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fr_re, fr_we, flush, busy;
  logic [7:0] awaddr, araddr, fr_rdata, fr_wdata, e8;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [11:0] fr_addr;
  logic [20:0] fetch_addr, flush_pc;
  int n_errors, total_checks, busy_cnt, flush_cnt;
  typedef struct packed {
    logic [3:0] st; logic ext; logic [3:0] bank; logic [15:0] ins;
    logic [20:0] pcx; logic [11:0] fa; logic [3:0] cyc;
  } row_t;
  row_t rows [0:16] = '{
    '{4'h0, 0, 0, 16'hE37F, 21'h1100, 0, 8},
    '{4'h1, 0, 0, 16'hE37F, 21'h1002, 0, 4},
    '{4'h0, 0, 0, 16'hE780, 21'h0F02, 0, 8},
    '{4'h8, 0, 0, 16'hE780, 21'h1002, 0, 4},
    '{4'hB, 0, 0, 16'hE501, 21'h1004, 0, 8},
    '{4'h4, 0, 0, 16'hE501, 21'h1002, 0, 4},
    '{4'hD, 0, 0, 16'hE1FF, 21'h1000, 0, 8},
    '{4'h2, 0, 0, 16'hE1FF, 21'h1002, 0, 4},
    '{4'h1, 0, 0, 16'hE202, 21'h1006, 0, 8},
    '{4'h8, 0, 0, 16'hE6FE, 21'h0FFE, 0, 8},
    '{4'hF, 0, 0, 16'hD400, 21'h0802, 0, 8},
    '{4'hF, 0, 0, 16'hD3FF, 21'h1800, 0, 8},
    '{4'h0, 0, 3, 16'h8F12, 21'h1002, 12'h312, 4},
    '{4'h0, 0, 3, 16'h8012, 21'h1002, 12'h012, 4},
    '{4'h0, 0, 0, 16'h8680, 21'h1002, 12'hF80, 4},
    '{4'h0, 1, 0, 16'h8A5F, 21'h1002, 12'h25F, 4},
    '{4'h0, 1, 0, 16'h8260, 21'h1002, 12'hF60, 4}};

  branch_and_bit_set_exec #(.ADDR_W(8), .PHASE_DIV(1))
    branch_and_bit_set_exec_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fr_addr(fr_addr), .fr_re(fr_re),
    .fr_rdata(fr_rdata), .fr_we(fr_we), .fr_wdata(fr_wdata), .flush(flush),
    .fetch_addr(fetch_addr), .busy(busy));
  file_mem_model #(.HOLD(1)) file_mem_model_i (.aclk(aclk),
    .fr_addr(fr_addr), .fr_re(fr_re), .fr_rdata(fr_rdata), .fr_we(fr_we),
    .fr_wdata(fr_wdata));

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (busy === 1'b1) busy_cnt++;
    if (flush === 1'b1) begin
      flush_cnt++;
      flush_pc = fetch_addr;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic guard(input int k);
    if (k > 200) begin
      n_errors++;
      $display("wrong value wait exp done got timeout");
      close_out();
    end
  endtask : guard
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    logic aw, w;
    k = 0; aw = 0; w = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 0; end
      if (!w && wready === 1'b1) begin w = 1; wvalid <= 0; end
      k++; guard(k);
    end
    while (bvalid !== 1'b1) begin @(posedge aclk); k++; guard(k); end
    r = bresp;
    bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin @(posedge aclk); k++; guard(k); end while (arready !== 1'b1);
    arvalid <= 0;
    do begin @(posedge aclk); k++; guard(k); end while (rvalid !== 1'b1);
    d = rdata; r = rresp;
    rready <= 0;
  endtask : axi_rd
  task automatic run_ins(input logic [15:0] ins);
    int k;
    k = 0;
    while (busy !== 1'b0) begin @(posedge aclk); k++; guard(k); end
    busy_cnt = 0; flush_cnt = 0;
    axi_wr(bexec_pkg::REG_INSTR, {16'h0, ins});
    do begin @(posedge aclk); k++; guard(k); end while (busy !== 1'b0);
  endtask : run_ins

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    n_errors = 0; total_checks = 0; aresetn = 0; awaddr = 0; awvalid = 0;
    wdata = 0; wstrb = 4'hF; wvalid = 0; bready = 0; araddr = 0;
    arvalid = 0; rready = 0;
    repeat (5) @(posedge aclk);
    `CHK("awready", 1'b1, awready)
    aresetn <= 1;
    axi_rd(bexec_pkg::REG_PC); `CHK("pc reset", 32'h0, d)
    axi_rd(bexec_pkg::REG_STATE); `CHK("state reset", 32'h0, d)
    axi_wr(bexec_pkg::REG_IDX_BASE, 32'h200);
    for (int i = 0; i < 17; i++) begin
      axi_wr(bexec_pkg::REG_STATUS, {28'h0, rows[i].st});
      axi_wr(bexec_pkg::REG_CTRL, {31'h0, rows[i].ext});
      axi_wr(bexec_pkg::REG_BANK, {28'h0, rows[i].bank});
      axi_wr(bexec_pkg::REG_PC, 32'h1000);
      run_ins(rows[i].ins);
      axi_rd(bexec_pkg::REG_PC); `CHK("pc", {11'h0, rows[i].pcx}, d)
      `CHK("cycles", 32'(rows[i].cyc), busy_cnt)
      `CHK("flushes", (rows[i].cyc == 8) ? 1 : 0, flush_cnt)
      if (rows[i].cyc == 8) `CHK("target", rows[i].pcx, flush_pc)
      axi_rd(bexec_pkg::REG_STATUS);
      `CHK("flags", rows[i].st, d[3:0])
      axi_rd(bexec_pkg::REG_STATE);
      `CHK("taken", rows[i].cyc == 8, d[1])
      e8 = (rows[i].fa[7:0] ^ 8'h5A) | (8'h01 << rows[i].ins[11:9]);
      if (rows[i].ins[15:12] == 4'h8)
        `CHK("bit", e8, file_mem_model_i.mem[rows[i].fa])
      $display("row %0d done", i);
    end
    axi_rd(8'h1C); `CHK("rresp", bexec_pkg::RESP_SLVERR, r)
    axi_wr(8'h1C, 32'h1); `CHK("bresp", bexec_pkg::RESP_SLVERR, r)
    axi_wr(bexec_pkg::REG_PC, 32'h1000);
    busy_cnt = 0;
    axi_wr(bexec_pkg::REG_INSTR, 32'hD400);
    axi_wr(bexec_pkg::REG_PC, 32'h0444);
    run_ins(16'hFFFF);
    `CHK("illegal cycles", 4, busy_cnt)
    axi_rd(bexec_pkg::REG_STATE); `CHK("illegal", 3'b100, d[2:0])
    axi_rd(bexec_pkg::REG_PC); `CHK("busy pc", 32'h0804, d)
    $display("awkward cases done");
    axi_wr(bexec_pkg::REG_INSTR, 32'hD400);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    `CHK("busy in reset", 1'b0, busy)
    aresetn <= 1;
    axi_rd(bexec_pkg::REG_PC); `CHK("pc after reset", 32'h0, d)
    $display("mid-run reset done");
    close_out();
  end
endmodule : tb_branch_and_bit_set_exec
